/* usb_device_test_and_endpoint_command.sv */
// transceiver control, compliance test entry and endpoint-wide commands
`default_nettype none
module usb_device_test_and_endpoint_command #(
  parameter int NUM_EP = usb_test_pkg::NUM_EP
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // register port
  input  wire logic [9:0]        addr,
  input  wire logic [7:0]        wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output var  logic [7:0]        rdata,
  // transceiver controls
  output var  logic [1:0]        transceiver_op_code,
  output var  logic              termination_choice,
  output var  logic              transceiver_choice,
  // test mode outputs
  output var  logic              idle_nak_test,
  output var  logic              j_state_test,
  output var  logic              k_state_test,
  output var  logic              packet_test,
  // endpoint commands
  output var  logic [NUM_EP-1:0] nak_all_endpoints,
  output var  logic [NUM_EP-2:0] stall_general_endpoints,
  output var  logic              flush_all_buffers,
  output var  logic              flush_control_buffer,
  input  wire logic              flush_all_done,
  // packet test completion
  input  wire logic              test_packet_sent,
  input  wire logic              in_err_clear,
  output var  logic              in_transfer_error_flag
);
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic [7:0] xcvr_r;
  logic [7:0] test_r;
  logic       sent_s1_r;
  logic       sent_s2_r;
  logic       sent_d_r;
  logic       flush_busy;
  logic       wr_xcvr;
  logic       wr_test;
  logic       wr_cmd;
  usb_test_pkg::test_state_t state_r;
  usb_test_pkg::test_state_t state_nxt;

  function automatic logic hit(input logic [9:0] a, input logic [9:0] ofs);
    hit = (a == ofs);
  endfunction

  assign wr_xcvr = wr && hit(addr, usb_test_pkg::XCVR_CTRL_OFS);
  assign wr_test = wr && hit(addr, usb_test_pkg::TEST_SEL_OFS);
  assign wr_cmd  = wr && hit(addr, usb_test_pkg::EP_CMD_OFS);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // transceiver control, reserved bits held at zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      xcvr_r <= usb_test_pkg::XCVR_RESET;
    end else if (wr_xcvr) begin
      xcvr_r <= wdata & usb_test_pkg::XCVR_WR_MASK;
    end
  end

  // test select
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      test_r <= usb_test_pkg::TEST_RESET;
    end else if (wr_test) begin
      test_r <= wdata & usb_test_pkg::TEST_WR_MASK;
    end
  end

  // read mux; command register reads zero with no effect
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        usb_test_pkg::XCVR_CTRL_OFS: rdata <= xcvr_r;
        usb_test_pkg::TEST_SEL_OFS:  rdata <= test_r;
        default:                     rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // transceiver outputs
  // ---------------------------------------------------------------
  // straight from the register; code meaning lives in the transceiver
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      // same bits as the register reset, so nothing steps after release
      transceiver_op_code <= usb_test_pkg::OP_NON_DRIVE;
      termination_choice  <= usb_test_pkg::XCVR_RESET[usb_test_pkg::TERM_BIT];
      transceiver_choice  <= usb_test_pkg::XCVR_RESET[usb_test_pkg::XCVR_BIT];
    end else begin
      transceiver_op_code <= xcvr_r[1:0];
      termination_choice  <= xcvr_r[usb_test_pkg::TERM_BIT];
      transceiver_choice  <= xcvr_r[usb_test_pkg::XCVR_BIT];
    end
  end

  // ---------------------------------------------------------------
  // test mode selection
  // ---------------------------------------------------------------
  // higher select bit wins if software sets several
  always_comb begin
    state_nxt = usb_test_pkg::TST_OFF;
    if (test_r[usb_test_pkg::TEST_EN_BIT]) begin
      if (test_r[usb_test_pkg::SEL_IDLE_NAK]) begin
        state_nxt = usb_test_pkg::TST_IDLE_NAK;
      end else if (test_r[usb_test_pkg::SEL_J]) begin
        state_nxt = usb_test_pkg::TST_J;
      end else if (test_r[usb_test_pkg::SEL_K]) begin
        state_nxt = usb_test_pkg::TST_K;
      end else if (test_r[usb_test_pkg::SEL_PACKET]) begin
        state_nxt = usb_test_pkg::TST_PACKET;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= usb_test_pkg::TST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // one output per mode, decoded from state_nxt at the same edge as the state register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      idle_nak_test <= 1'b0;
      j_state_test  <= 1'b0;
      k_state_test  <= 1'b0;
      packet_test   <= 1'b0;
    end else begin
      idle_nak_test <= 1'b0;
      j_state_test  <= 1'b0;
      k_state_test  <= 1'b0;
      packet_test   <= 1'b0;
      case (state_nxt)
        usb_test_pkg::TST_IDLE_NAK: idle_nak_test <= 1'b1;
        usb_test_pkg::TST_J:        j_state_test  <= 1'b1;
        usb_test_pkg::TST_K:        k_state_test  <= 1'b1;
        usb_test_pkg::TST_PACKET:   packet_test   <= 1'b1;
        default:                    ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // packet test completion flag
  // ---------------------------------------------------------------
  // the engine may sit on another clock, so its strobe is synchronised
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sent_s1_r <= 1'b0;
      sent_s2_r <= 1'b0;
      sent_d_r  <= 1'b0;
    end else begin
      sent_s1_r <= test_packet_sent;
      sent_s2_r <= sent_s1_r;
      sent_d_r  <= sent_s2_r;
    end
  end

  // set wins over clear so a completion is never lost
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      in_transfer_error_flag <= 1'b0;
    end else if (packet_test && sent_s2_r && !sent_d_r) begin
      in_transfer_error_flag <= 1'b1;
    end else if (in_err_clear) begin
      in_transfer_error_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // endpoint commands
  // ---------------------------------------------------------------
  // one-cycle set pulses; nothing of the write is stored
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      nak_all_endpoints       <= '0;
      stall_general_endpoints <= '0;
      flush_control_buffer    <= 1'b0;
    end else begin
      nak_all_endpoints       <= {NUM_EP{wr_cmd && wdata[usb_test_pkg::CMD_NAK_BIT]}};
      stall_general_endpoints <=
        {(NUM_EP-1){wr_cmd && wdata[usb_test_pkg::CMD_STALL_BIT]}};
      flush_control_buffer    <= wr_cmd && wdata[usb_test_pkg::CMD_FLUSH_CTL];
    end
  end

  // flush-all stays up until the buffers report success
  flush_sequencer u_flush (
    .ref_clk (ref_clk),
    .rst     (rst),
    .start   (wr_cmd && wdata[usb_test_pkg::CMD_FLUSH_ALL]),
    .done    (flush_all_done),
    .busy_r  (flush_busy)
  );

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flush_all_buffers <= 1'b0;
    end else begin
      flush_all_buffers <= flush_busy && !flush_all_done;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence cmd_wr_s(int b);
    wr_cmd && wdata[b];
  endsequence

  // a transceiver write followed by a quiet cycle
  sequence xcvr_wr_s;
    wr_xcvr ##1 !wr_xcvr;
  endsequence

  // a completion strobe edge seen while the packet test runs
  sequence packet_done_s;
    packet_test && sent_s2_r && !sent_d_r;
  endsequence

  AST_NAK_ALL: assert property (@(posedge ref_clk) disable iff (rst)
    cmd_wr_s(usb_test_pkg::CMD_NAK_BIT) |=> (&nak_all_endpoints))
    else $error("nak all not raised");
  AST_STALL_GEN: assert property (@(posedge ref_clk) disable iff (rst)
    cmd_wr_s(usb_test_pkg::CMD_STALL_BIT) |=> (&stall_general_endpoints))
    else $error("stall not raised");
  AST_STALL_PULSE: assert property (@(posedge ref_clk) disable iff (rst)
    !wr_cmd |=> (stall_general_endpoints == '0))
    else $error("stall without command");
  AST_FLUSH_CTL: assert property (@(posedge ref_clk) disable iff (rst)
    flush_control_buffer |=> !flush_control_buffer || $past(wr_cmd))
    else $error("control flush retained");
  AST_FLUSH_ALL: assert property (@(posedge ref_clk) disable iff (rst)
    cmd_wr_s(usb_test_pkg::CMD_FLUSH_ALL) ##1 !flush_all_done |=> flush_all_buffers)
    else $error("flush all not started");
  AST_FLUSH_END: assert property (@(posedge ref_clk) disable iff (rst)
    flush_all_done && !wr_cmd |=> !flush_all_buffers)
    else $error("flush all did not clear");
  AST_OP_CODE: assert property (@(posedge ref_clk) disable iff (rst)
    xcvr_wr_s |=> transceiver_op_code == $past(xcvr_r[1:0]))
    else $error("op code mismatch");
  AST_J_TEST: assert property (@(posedge ref_clk) disable iff (rst)
    test_r[usb_test_pkg::TEST_EN_BIT] && test_r[usb_test_pkg::SEL_J] &&
      !test_r[usb_test_pkg::SEL_IDLE_NAK] |=> j_state_test && !k_state_test)
    else $error("j test not entered");
  AST_IDLE_NAK: assert property (@(posedge ref_clk) disable iff (rst)
    (test_r[usb_test_pkg::SEL_IDLE_NAK] && test_r[usb_test_pkg::TEST_EN_BIT]) |=> idle_nak_test)
    else $error("idle nak test not entered");
  AST_NO_TEST: assert property (@(posedge ref_clk) disable iff (rst)
    !test_r[usb_test_pkg::TEST_EN_BIT] |=>
      !(idle_nak_test || j_state_test || k_state_test || packet_test))
    else $error("test without enable");
  AST_CMD_READ: assert property (@(posedge ref_clk) disable iff (rst)
    rd && hit(addr, usb_test_pkg::EP_CMD_OFS) |=> rdata == 8'h00)
    else $error("command read not zero");
  AST_ERR_FLAG: assert property (@(posedge ref_clk) disable iff (rst)
    packet_done_s |=> in_transfer_error_flag)
    else $error("in error flag not set");

  // ---------------------------------------------------------------
  // checks on test entry, transceiver outputs, the flag and endpoint commands
  // ---------------------------------------------------------------
  // enable with the k select and no higher-priority select beside it
  sequence k_pick_s;
    test_r[usb_test_pkg::TEST_EN_BIT] && test_r[usb_test_pkg::SEL_K] &&
      !test_r[usb_test_pkg::SEL_J] && !test_r[usb_test_pkg::SEL_IDLE_NAK];
  endsequence

  // enable with only the packet select among the four
  sequence packet_pick_s;
    test_r[usb_test_pkg::TEST_EN_BIT] && test_r[usb_test_pkg::SEL_PACKET] &&
      !test_r[usb_test_pkg::SEL_K] && !test_r[usb_test_pkg::SEL_J] &&
      !test_r[usb_test_pkg::SEL_IDLE_NAK];
  endsequence

  // k test entry; neither higher test may show beside it
  AST_K_TEST: assert property (@(posedge ref_clk) disable iff (rst)
    k_pick_s |=> k_state_test && !j_state_test && !idle_nak_test)
    else $error("k test not entered");

  // packet test entry; the engine then frames the pattern with pid and crc
  AST_PACKET_TEST: assert property (@(posedge ref_clk) disable iff (rst)
    packet_pick_s |=> packet_test && !k_state_test)
    else $error("packet test not entered");

  // never two test modes at once, whatever software wrote
  AST_ONE_TEST: assert property (@(posedge ref_clk) disable iff (rst)
    $onehot0({idle_nak_test, j_state_test, k_state_test, packet_test}))
    else $error("two test modes at once");

  // the state register stays one-hot and agrees with the packet output
  AST_STATE_CODE: assert property (@(posedge ref_clk) disable iff (rst)
    $onehot(state_r) && ((state_r == usb_test_pkg::TST_PACKET) == packet_test))
    else $error("test state code broken");

  // termination choice follows the transceiver register one cycle later, two cycles after the write
  AST_TERM_CHOICE: assert property (@(posedge ref_clk) disable iff (rst)
    xcvr_wr_s |=> termination_choice == $past(xcvr_r[usb_test_pkg::TERM_BIT]))
    else $error("termination choice mismatch");

  // transceiver choice follows the same write
  AST_XCVR_CHOICE: assert property (@(posedge ref_clk) disable iff (rst)
    xcvr_wr_s |=> transceiver_choice == $past(xcvr_r[usb_test_pkg::XCVR_BIT]))
    else $error("transceiver choice mismatch");

  // the flag is sticky until software clears it
  AST_FLAG_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
    in_transfer_error_flag && !in_err_clear |=> in_transfer_error_flag)
    else $error("in error flag dropped");

  // a clear with no packet test running always drops the flag
  AST_FLAG_CLEAR: assert property (@(posedge ref_clk) disable iff (rst)
    in_err_clear && !packet_test |=> !in_transfer_error_flag)
    else $error("in error flag not cleared");

  // flush-all stays up while the buffers have not answered
  AST_FLUSH_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
    flush_all_buffers && !flush_all_done |=> flush_all_buffers)
    else $error("flush all dropped early");

  // the control flush follows bit 0 of a command write
  AST_CTL_FLUSH: assert property (@(posedge ref_clk) disable iff (rst)
    cmd_wr_s(usb_test_pkg::CMD_FLUSH_CTL) |=> flush_control_buffer)
    else $error("control flush not raised");

  // a read of the command register fires no command
  AST_CMD_QUIET: assert property (@(posedge ref_clk) disable iff (rst)
    rd && !wr && hit(addr, usb_test_pkg::EP_CMD_OFS) |=>
      (nak_all_endpoints == '0) && (stall_general_endpoints == '0) && !flush_control_buffer)
    else $error("command read had side effects");
endmodule
`default_nettype wire

/* usb_test_pkg.sv */
// constants, offsets and state codes for the usb test and endpoint command block
//
// How it works
// - op code 00 normal, 01 non-driving, 10 no stuff/nrzi, 11 power-down.
// - with test enable set, the highest set test-select bit picks the test mode.
// - select bit 3 then enable enters the idle nak test.
// - select bit 2 then enable enters j test; needs speed selects and code 10.
// - select bit 1 then enable enters k test; needs speed selects and code 10.
// - software loads 53 pattern bytes; the engine appends data0 pid and crc.
// - software clears in error flag first; device sets it per sent test packet.
// - command bit 7 sets forced nak on every endpoint.
// - command bit 6 sets forced stall on the three general endpoints.
// - command bit 5 flushes all buffers and clears itself when flush succeeds.
// - command bit 0 flushes the control buffer and is not retained.
// - termination and transceiver choice bits: 0 high speed, 1 full speed.
`default_nettype none
package usb_test_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [9:0] XCVR_CTRL_OFS  = 10'h105;
  localparam logic [9:0] TEST_SEL_OFS   = 10'h106;
  localparam logic [9:0] RSVD_OFS       = 10'h107;
  localparam logic [9:0] EP_CMD_OFS     = 10'h108;
  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int         TERM_BIT       = 7;
  localparam int         XCVR_BIT       = 6;
  localparam int         TEST_EN_BIT    = 7;
  localparam int         SEL_IDLE_NAK   = 3;
  localparam int         SEL_J          = 2;
  localparam int         SEL_K          = 1;
  localparam int         SEL_PACKET     = 0;
  localparam int         CMD_NAK_BIT    = 7;
  localparam int         CMD_STALL_BIT  = 6;
  localparam int         CMD_FLUSH_ALL  = 5;
  localparam int         CMD_FLUSH_CTL  = 0;
  localparam logic [7:0] XCVR_RESET     = 8'h41;
  localparam logic [7:0] TEST_RESET     = 8'h00;
  localparam logic [7:0] TEST_WR_MASK   = 8'h8f;
  localparam logic [7:0] XCVR_WR_MASK   = 8'hc3;
  localparam int         NUM_EP         = 4;
  // ---------------------------------------------------------------
  // operating mode codes
  // ---------------------------------------------------------------
  localparam logic [1:0] OP_NORMAL      = 2'h0;
  localparam logic [1:0] OP_NON_DRIVE   = 2'h1;
  localparam logic [1:0] OP_NO_STUFF    = 2'h2;
  localparam logic [1:0] OP_POWER_DOWN  = 2'h3;
  // ---------------------------------------------------------------
  // test state machine
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    TST_OFF      = 5'h01,
    TST_IDLE_NAK = 5'h02,
    TST_J        = 5'h04,
    TST_K        = 5'h08,
    TST_PACKET   = 5'h10
  } test_state_t;
endpackage
`default_nettype wire

/* flush_sequencer.sv */
// flush sequencer: holds a flush request until the buffer logic acknowledges
`default_nettype none
module flush_sequencer (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // request and completion
  input  wire logic start,
  input  wire logic done,
  output var  logic busy_r
);
  // start wins over done so a back-to-back request is never dropped
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      busy_r <= 1'b0;
    end else if (start) begin
      busy_r <= 1'b1;
    end else if (done) begin
      busy_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* engine_model.sv */
// far-side buffer and serial engine model: flush answer and test packet pulses
`default_nettype none
module engine_model (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // requests from the block, delay from the bench
  input  wire logic       flush_all_buffers,
  input  wire logic       packet_test,
  input  wire logic [3:0] delay,
  // answers
  output var  logic       flush_all_done,
  output var  logic       test_packet_sent
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  int pk;
  initial begin
    flush_all_done   = 1'b0;
    test_packet_sent = 1'b0;
  end
  // ---------------------------------------------------------------
  // answers: flush slow or prompt as the bench sets delay, test packets every 12 cycles
  // ---------------------------------------------------------------
  // done is one cycle only, so a held request is not answered twice
  always @(posedge ref_clk) begin
    flush_all_done   <= 1'b0;
    test_packet_sent <= 1'b0;
    if (rst) begin
      cnt = 0;
      pk  = 0;
    end else begin
      if (flush_all_buffers && !flush_all_done) begin
        cnt++;
        if (cnt > delay) begin
          flush_all_done <= 1'b1;
          cnt = 0;
        end
      end else cnt = 0;
      // one sent test packet every 12 cycles while testing
      if (packet_test) begin
        pk++;
        if (pk == 12) begin
          test_packet_sent <= 1'b1;
          pk = 0;
        end
      end else pk = 0;
    end
  end
endmodule
`default_nettype wire

/* tb.sv */
// self-checking bench for the usb test and endpoint command block
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin failures++; \
  $display("MISMATCH %s exp %h got %h", n, e, a); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, in_err_clear = 1'b0;
  logic [9:0] addr = 10'h000;
  logic [7:0] wdata = 8'h00, rdata, xm, tm;
  logic [1:0] op;
  logic term, xsel, t_nak, t_j, t_k, t_pk, f_all, f_ctl, f_done, sent, err;
  logic [3:0] nak, dly = 4'h2;
  logic [2:0] stall;
  logic [31:0] seed = 32'h2dd47cc5;
  int failures = 0, samples_checked = 0, cyc = 0, n_nak = 0, n_stall = 0, n_ctl = 0, i;
  always #10 ref_clk = ~ref_clk;
  usb_device_test_and_endpoint_command u_dut (.ref_clk(ref_clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .transceiver_op_code(op),
    .termination_choice(term), .transceiver_choice(xsel), .idle_nak_test(t_nak),
    .j_state_test(t_j), .k_state_test(t_k), .packet_test(t_pk), .nak_all_endpoints(nak),
    .stall_general_endpoints(stall), .flush_all_buffers(f_all), .flush_control_buffer(f_ctl),
    .flush_all_done(f_done), .test_packet_sent(sent), .in_err_clear(in_err_clear),
    .in_transfer_error_flag(err));
  engine_model u_eng (.ref_clk(ref_clk), .rst(rst), .flush_all_buffers(f_all),
    .packet_test(t_pk), .delay(dly), .flush_all_done(f_done), .test_packet_sent(sent));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic end_sim();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // a hang counts as a mismatch and still reaches the verdict
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end
  // command pulses: each write gives exactly one full-width cycle
  always @(negedge ref_clk) if (!rst) begin
    if (nak !== 4'h0) begin n_nak++; `CHK("nak", 4'hf, nak) end
    if (stall !== 3'h0) begin n_stall++; `CHK("stall", 3'h7, stall) end
    if (f_ctl !== 1'b0) n_ctl++;
  end
  task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    if (a == 10'h105) xm = d & 8'hc3;
    if (a == 10'h106) tm = d & 8'h8f;
  endtask
  task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 `CHK("rdata", e, rdata)
  endtask
  // outputs against the model, after the two-cycle settle
  task automatic chk_outs();
    logic [3:0] t;
    repeat (3) @(posedge ref_clk);
    #1 t = !tm[7] ? 4'h0 : tm[3] ? 4'h8 : tm[2] ? 4'h4 : tm[1] ? 4'h2 : {3'h0, tm[0]};
    `CHK("op", xm[1:0], op)
    `CHK("sel", xm[7:6], {term, xsel})
    `CHK("test", t, {t_nak, t_j, t_k, t_pk})
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    xm = 8'h41;
    tm = 8'h00;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rd_chk(10'h105, 8'h41);
    rd_chk(10'h106, 8'h00);
    chk_outs();
    // random transceiver settings, reserved bits dropped
    for (i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      wr_reg(10'h105, seed[7:0]);
      rd_chk(10'h105, xm);
      chk_outs();
    end
    // select first, then enable, for each test; speed and code 10 set first
    wr_reg(10'h105, 8'h02);
    for (i = 3; i >= 0; i--) begin
      wr_reg(10'h106, 8'h01 << i);
      chk_outs();
      wr_reg(10'h106, 8'h80 | (8'h01 << i));
      chk_outs();
    end
    wr_reg(10'h106, 8'hff);
    rd_chk(10'h106, 8'h8f);
    chk_outs();
    // reserved and unmapped reads
    rd_chk(10'h107, 8'h00);
    rd_chk(10'h1ff, 8'h00);
    // endpoint commands, then a read that must not fire them
    wr_reg(10'h108, 8'h80);
    wr_reg(10'h108, 8'h40);
    wr_reg(10'h108, 8'h01);
    wr_reg(10'h108, 8'hc1);
    rd_chk(10'h108, 8'h00);
    repeat (3) @(posedge ref_clk);
    `CHK("nak_n", 2, n_nak)
    `CHK("stall_n", 2, n_stall)
    `CHK("ctl_n", 2, n_ctl)
    `CHK("fall", 1'b0, f_all)
    // flush-all, slow then prompt far side; bit clears after done
    // buffer areas count as set up and no dma runs here
    for (int k = 0; k < 2; k++) begin
      dly <= (k == 0) ? 4'hc : 4'h0;
      wr_reg(10'h108, 8'h20);
      // the sequencer stage puts the output one edge behind the write
      @(posedge ref_clk);
      #1 `CHK("fall_on", 1'b1, f_all)
      i = 0;
      while (f_all === 1'b1 && i < 40) begin
        @(posedge ref_clk);
        #1 i++;
      end
      `CHK("fall_off", 1'b0, f_all)
      `CHK("fall_wait", 1'b1, i > ((k == 0) ? 12 : 0))
    end
    // packet test: flag set per sent packet, cleared by software
    // endpoint 0xf, detection off and negotiation off live outside
    wr_reg(10'h106, 8'h81);
    repeat (20) @(posedge ref_clk);
    #1 `CHK("flag", 1'b1, err)
    wr_reg(10'h106, 8'h00);
    repeat (6) @(posedge ref_clk);
    in_err_clear <= 1'b1;
    @(posedge ref_clk);
    in_err_clear <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 `CHK("flag_clr", 1'b0, err)
    wr_reg(10'h106, 8'h81);
    repeat (20) @(posedge ref_clk);
    #1 `CHK("flag_again", 1'b1, err)
    // reset again mid-run
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    xm = 8'h41;
    tm = 8'h00;
    rd_chk(10'h106, 8'h00);
    chk_outs();
    `CHK("flag_rst", 1'b0, err)
    end_sim();
  end
endmodule
`default_nettype wire
